// ### inc/tpps_cfg.svh
`ifndef TPPS_CFG_SVH
`define TPPS_CFG_SVH
// ==========================================
// timing figures (us) and clock rate
`define TPPS_CLK_MHZ 100
`define TPPS_CC_ON_US 1300
`define TPPS_SBU_ON_US 1300
`define TPPS_PULLDOWN_RELEASE_US 5700
`define TPPS_FAULT_RECOVER_US 5000
`define TPPS_CC_DEBOUNCE_US 900
`define TPPS_SBU_DEBOUNCE_US 600
`define TPPS_CYC(us) ((us) * `TPPS_CLK_MHZ)
`define TPPS_CNT_W 20
`endif

// ### inc/tpps_pkg.sv
`default_nettype none
package tpps_pkg;
   typedef enum logic [2:0] {TPPS_OFF, TPPS_POWERUP, TPPS_RUN, TPPS_OVP, TPPS_RECOVER, TPPS_OTP} tpps_state_t;
endpackage
`default_nettype wire

// ### rtl/tpps_sync.sv
`include "tpps_cfg.svh"
`default_nettype none
// ==========================================
// two-flop synchroniser, one per detector line
module tpps_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // lines
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ### rtl/tpps_sequencer.sv
`include "tpps_cfg.svh"
`default_nettype none
module tpps_sequencer #(
   parameter int CNT_W = `TPPS_CNT_W,
   parameter int CC_ON_CYC = `TPPS_CYC(`TPPS_CC_ON_US),
   parameter int SBU_ON_CYC = `TPPS_CYC(`TPPS_SBU_ON_US),
   parameter int PD_RELEASE_CYC = `TPPS_CYC(`TPPS_PULLDOWN_RELEASE_US),
   parameter int RECOVER_CYC = `TPPS_CYC(`TPPS_FAULT_RECOVER_US),
   parameter int CC_DEB_CYC = `TPPS_CYC(`TPPS_CC_DEBOUNCE_US),
   parameter int SBU_DEB_CYC = `TPPS_CYC(`TPPS_SBU_DEBOUNCE_US)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // detectors (asynchronous)
   input wire logic supply_lockout,
   input wire logic cc_overvoltage,
   input wire logic sbu_overvoltage,
   input wire logic over_temp,
   // pull-down straps
   input wire logic pulldown_gate_one,
   input wire logic pulldown_gate_two,
   // switch controls
   output logic cc_switch_on,
   output logic sbu_switch_on,
   output logic dead_battery_pulldown,
   // open-drain fault flag
   output logic fault_flag_n_o,
   output logic fault_flag_n_oe
);
   logic [3:0] det;
   logic lock_s, ccov_s, sbuov_s, otp_s;
   logic [CNT_W-1:0] timer_q, ccdeb_q, sbudeb_q;
   logic ov_clear;
   tpps_pkg::tpps_state_t state_q;
   logic cc_q, sbu_q, pd_q, flag_q;

   // ==========================================
   // input synchronisers
   // supply-good is synchronised, so a cleared synchroniser reads as lockout
   tpps_sync #(.WIDTH(4)) tpps_sync_inst (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in({!supply_lockout, cc_overvoltage, sbu_overvoltage, over_temp}),
      .sync_out(det)
   );
   assign lock_s = !det[3];
   assign ccov_s = det[2];
   assign sbuov_s = det[1];
   assign otp_s = det[0];

   // ==========================================
   // overvoltage release debounce
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n || ccov_s)
         ccdeb_q <= '0;
      else if (ccdeb_q != CNT_W'(CC_DEB_CYC))
         ccdeb_q <= ccdeb_q + 1'b1;
      if (!reset_n || sbuov_s)
         sbudeb_q <= '0;
      else if (sbudeb_q != CNT_W'(SBU_DEB_CYC))
         sbudeb_q <= sbudeb_q + 1'b1;
   end
   assign ov_clear = (ccdeb_q == CNT_W'(CC_DEB_CYC)) && (sbudeb_q == CNT_W'(SBU_DEB_CYC));

   // ==========================================
   // sequencing state machine
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state_q <= tpps_pkg::TPPS_OFF;
         timer_q <= '0;
      end
      else if (lock_s)
      begin
         state_q <= tpps_pkg::TPPS_OFF;
         timer_q <= '0;
      end
      else
      begin
         timer_q <= timer_q + 1'b1;
         case (state_q)
            tpps_pkg::TPPS_OFF:
            begin
               state_q <= tpps_pkg::TPPS_POWERUP;
               timer_q <= '0;
            end
            tpps_pkg::TPPS_POWERUP, tpps_pkg::TPPS_RUN:
            begin
               if (otp_s)
               begin
                  state_q <= tpps_pkg::TPPS_OTP;
                  timer_q <= '0;
               end
               else if (ccov_s || sbuov_s)
               begin
                  state_q <= tpps_pkg::TPPS_OVP;
                  timer_q <= '0;
               end
               else if (state_q == tpps_pkg::TPPS_POWERUP && timer_q >= CNT_W'(PD_RELEASE_CYC))
                  state_q <= tpps_pkg::TPPS_RUN;
               else if (state_q == tpps_pkg::TPPS_RUN)
                  timer_q <= timer_q;
            end
            tpps_pkg::TPPS_OVP:
            begin
               timer_q <= '0;
               if (otp_s)
                  state_q <= tpps_pkg::TPPS_OTP;
               else if (ov_clear)
                  state_q <= tpps_pkg::TPPS_RECOVER;
            end
            tpps_pkg::TPPS_RECOVER:
            begin
               if (otp_s)
               begin
                  state_q <= tpps_pkg::TPPS_OTP;
                  timer_q <= '0;
               end
               else if (ccov_s || sbuov_s)
               begin
                  state_q <= tpps_pkg::TPPS_OVP;
                  timer_q <= '0;
               end
               else if (timer_q >= CNT_W'(RECOVER_CYC))
                  state_q <= tpps_pkg::TPPS_RUN;
            end
            tpps_pkg::TPPS_OTP:
            begin
               timer_q <= '0;
               if (!otp_s)
                  state_q <= tpps_pkg::TPPS_POWERUP;
            end
            default:
            begin
               state_q <= tpps_pkg::TPPS_OFF;
               timer_q <= '0;
            end
         endcase
      end
   end

   // ==========================================
   // switch and flag registers
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         cc_q <= 1'b0;
         sbu_q <= 1'b0;
         pd_q <= 1'b1;
         flag_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            tpps_pkg::TPPS_POWERUP:
            begin
               cc_q <= !lock_s && timer_q >= CNT_W'(CC_ON_CYC);
               sbu_q <= !lock_s && timer_q >= CNT_W'(SBU_ON_CYC);
               pd_q <= 1'b1;
               flag_q <= 1'b0;
            end
            tpps_pkg::TPPS_RUN, tpps_pkg::TPPS_RECOVER:
            begin
               cc_q <= !lock_s && state_q == tpps_pkg::TPPS_RUN;
               sbu_q <= !lock_s && state_q == tpps_pkg::TPPS_RUN;
               pd_q <= lock_s || state_q == tpps_pkg::TPPS_RECOVER;
               flag_q <= !lock_s && state_q == tpps_pkg::TPPS_RECOVER;
            end
            tpps_pkg::TPPS_OVP:
            begin
               cc_q <= 1'b0;
               sbu_q <= 1'b0;
               pd_q <= 1'b1;
               flag_q <= !lock_s;
            end
            tpps_pkg::TPPS_OTP:
            begin
               cc_q <= 1'b0;
               sbu_q <= 1'b0;
               pd_q <= lock_s;
               flag_q <= !lock_s;
            end
            default:
            begin
               cc_q <= 1'b0;
               sbu_q <= 1'b0;
               pd_q <= 1'b1;
               flag_q <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================
   // outputs; lockout acts without waiting for the machine
   assign cc_switch_on = cc_q && !lock_s;
   assign sbu_switch_on = sbu_q && !lock_s;
   assign dead_battery_pulldown = (pd_q || lock_s) && (pulldown_gate_one || pulldown_gate_two);
   assign fault_flag_n_o = 1'b0;
   assign fault_flag_n_oe = flag_q && !lock_s;
endmodule
`default_nettype wire

// ### testbench/tpps_ctrl_model.sv
`default_nettype none
module tpps_ctrl_model (
   // flag pad from the block
   input wire logic fault_flag_n_o,
   input wire logic fault_flag_n_oe,
   // level seen by the controller
   output logic flag_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====
   // pad rests on the pull-up unless the drain pulls low
   assign flag_n = fault_flag_n_oe ? fault_flag_n_o : 1'h1;
endmodule
`default_nettype wire

// ### testbench/tpps_sequencer_monitor.sv
`default_nettype none
module tpps_sequencer_monitor #(
   parameter int CC_ON_CYC = 20,
   parameter int SBU_ON_CYC = 30,
   parameter int PD_RELEASE_CYC = 60,
   parameter int RECOVER_CYC = 50,
   parameter int CC_DEB_CYC = 9
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // detectors and straps
   input wire logic supply_lockout,
   input wire logic cc_overvoltage,
   input wire logic sbu_overvoltage,
   input wire logic over_temp,
   input wire logic pulldown_gate_one,
   input wire logic pulldown_gate_two,
   // outputs
   input wire logic cc_switch_on,
   input wire logic sbu_switch_on,
   input wire logic dead_battery_pulldown,
   input wire logic fault_flag_n_o,
   input wire logic fault_flag_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====
   // sequencing checks
   localparam int REL_LO = CC_DEB_CYC + RECOVER_CYC - 2;
   wire logic strap = pulldown_gate_one | pulldown_gate_two;
   wire logic quiet = !over_temp && !cc_overvoltage && !sbu_overvoltage;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   lockout_off_a:
      assert property (supply_lockout [*3] |-> !cc_switch_on && !sbu_switch_on && !fault_flag_n_oe
         && (dead_battery_pulldown || !strap)) else $error("lockout outputs wrong");
   ovp_off_a:
      assert property (((cc_overvoltage || sbu_overvoltage) && !over_temp && !supply_lockout) [*5] |->
         !cc_switch_on && !sbu_switch_on && fault_flag_n_oe && (dead_battery_pulldown || !strap))
         else $error("overvoltage outputs wrong");
   otp_off_a:
      assert property ((over_temp && !supply_lockout) [*5] |-> !cc_switch_on && !sbu_switch_on
         && fault_flag_n_oe && !dead_battery_pulldown) else $error("shutdown outputs wrong");
   drain_low_a:
      assert property (fault_flag_n_oe |-> !fault_flag_n_o) else $error("flag drive not low");
   switch_first_a:
      assert property ($fell(dead_battery_pulldown) && strap && !fault_flag_n_oe |-> cc_switch_on
         && sbu_switch_on) else $error("pulldown left before switches");
   rejoin_a:
      assert property ($fell(fault_flag_n_oe) && $past(dead_battery_pulldown) && !supply_lockout |->
         !dead_battery_pulldown && cc_switch_on && sbu_switch_on) else $error("recovery not joint");
   recover_time_a:
      assert property ($fell(cc_overvoltage) && fault_flag_n_oe && !sbu_overvoltage && !over_temp |->
         ##REL_LO fault_flag_n_oe ##[1:10] !fault_flag_n_oe) else $error("recovery time wrong");
   cc_delay_a:
      assert property ($fell(supply_lockout) && quiet |-> ##CC_ON_CYC !cc_switch_on ##[1:10] cc_switch_on)
         else $error("cc turn-on time wrong");
   sbu_delay_a:
      assert property ($fell(supply_lockout) && quiet |-> ##SBU_ON_CYC !sbu_switch_on ##[1:10] sbu_switch_on)
         else $error("sbu turn-on time wrong");
   pd_delay_a:
      assert property ($fell(supply_lockout) && quiet && strap |-> ##PD_RELEASE_CYC dead_battery_pulldown
         ##[1:12] !dead_battery_pulldown) else $error("pulldown release time wrong");
   otp_end_a:
      assert property ($fell(over_temp) && !supply_lockout && strap |-> ##[2:8] dead_battery_pulldown
         && !cc_switch_on) else $error("pulldown not ahead of cc");
endmodule
bind tpps_sequencer tpps_sequencer_monitor #(.CC_ON_CYC(CC_ON_CYC), .SBU_ON_CYC(SBU_ON_CYC),
   .PD_RELEASE_CYC(PD_RELEASE_CYC), .RECOVER_CYC(RECOVER_CYC), .CC_DEB_CYC(CC_DEB_CYC)) tpps_mon_inst (
   .sys_clk, .reset_n, .supply_lockout, .cc_overvoltage, .sbu_overvoltage, .over_temp, .pulldown_gate_one,
   .pulldown_gate_two, .cc_switch_on, .sbu_switch_on, .dead_battery_pulldown, .fault_flag_n_o, .fault_flag_n_oe);
`default_nettype wire

// ### testbench/tpps_sequencer_tb.sv
`default_nettype none
module tpps_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ====
   // stimulus and observed lines
   logic sys_clk = 1'h0, reset_n = 1'h0, supply_lockout = 1'h1, cc_overvoltage = 1'h0;
   logic sbu_overvoltage = 1'h0, over_temp = 1'h0, pulldown_gate_one = 1'h1, pulldown_gate_two = 1'h1;
   logic cc_switch_on, sbu_switch_on, dead_battery_pulldown, fault_flag_n_o, fault_flag_n_oe, flag_n;
   int num_errors = 0;
   int total_checks = 0;
   localparam int CC_ON = 20;
   localparam int SBU_ON = 30;
   localparam int PD_REL = 60;
   localparam int RECOVER = 50;
   localparam int CC_DEB = 9;
   localparam int SBU_DEB = 6;
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end
   tpps_sequencer #(.CC_ON_CYC(CC_ON), .SBU_ON_CYC(SBU_ON), .PD_RELEASE_CYC(PD_REL), .RECOVER_CYC(RECOVER),
      .CC_DEB_CYC(CC_DEB), .SBU_DEB_CYC(SBU_DEB)) tpps_sequencer_inst (.sys_clk, .reset_n, .supply_lockout, .cc_overvoltage,
      .sbu_overvoltage, .over_temp, .pulldown_gate_one, .pulldown_gate_two, .cc_switch_on, .sbu_switch_on,
      .dead_battery_pulldown, .fault_flag_n_o, .fault_flag_n_oe);
   tpps_ctrl_model tpps_ctrl_model_inst (.fault_flag_n_o, .fault_flag_n_oe, .flag_n);
   // ====
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input string name, input logic seen, input logic exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", name, exp, seen);
      end
   endtask
   // expected bits: cc, sbu, pulldown, flag level
   task automatic outs(input logic [3:0] e);
      chk("cc_switch_on", cc_switch_on, e[3]);
      chk("sbu_switch_on", sbu_switch_on, e[2]);
      chk("dead_battery_pulldown", dead_battery_pulldown, e[1]);
      chk("flag_n", flag_n, e[0]);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #100000;
      num_errors++;
      stop_test();
   end
   // ====
   // scenarios
   initial
   begin
      cyc(8);
      reset_n = 1'h1;
      cc_overvoltage = 1'h1;
      cyc(6);
      outs(4'h3);
      cc_overvoltage = 1'h0;
      supply_lockout = 1'h0;
      cyc(28);
      outs(4'hb);
      cyc(12);
      outs(4'hf);
      cyc(40);
      outs(4'hd);
      for (int k = 0; k < 2; k++)
      begin
         {cc_overvoltage, sbu_overvoltage} = (k == 0) ? 2'h2 : 2'h1;
         cyc(8);
         outs(4'h2);
         {cc_overvoltage, sbu_overvoltage} = 2'h0;
         cyc(30);
         outs(4'h2);
         cyc(40);
         outs(4'hd);
      end
      over_temp = 1'h1;
      cyc(8);
      outs(4'h0);
      over_temp = 1'h0;
      cyc(6);
      outs(4'h3);
      cyc(80);
      outs(4'hd);
      supply_lockout = 1'h1;
      cyc(4);
      outs(4'h3);
      pulldown_gate_one = 1'h0;
      cyc(2);
      outs(4'h3);
      pulldown_gate_two = 1'h0;
      cyc(2);
      outs(4'h1);
      pulldown_gate_one = 1'h1;
      pulldown_gate_two = 1'h1;
      supply_lockout = 1'h0;
      cyc(50);
      outs(4'hf);
      reset_n = 1'h0;
      cyc(2);
      outs(4'h3);
      reset_n = 1'h1;
      cyc(80);
      outs(4'hd);
      stop_test();
   end
endmodule
`default_nettype wire
